//--- common/tec_pkg.sv
// constants and register map of the receive error counter block
package tec_pkg;
	// ======================================================
	// counter widths
	localparam int TEC_LINE_W = 16;
	localparam int TEC_PATH_W = 12;
	localparam int TEC_MF_W = 12;
	// ======================================================
	// register indices, byte address is four times the index
	localparam logic [5:0] TEC_IDX_LINE_HIGH = 6'h23;
	localparam logic [5:0] TEC_IDX_LINE_LOW = 6'h24;
	localparam logic [5:0] TEC_IDX_PATH_MF_HIGH = 6'h25;
	localparam logic [5:0] TEC_IDX_PATH_LOW = 6'h26;
	localparam logic [5:0] TEC_IDX_MF_LOW = 6'h27;
	localparam logic [5:0] TEC_IDX_CTRL = 6'h30;
	localparam logic [5:0] TEC_IDX_INT_STATUS = 6'h31;
	localparam logic [5:0] TEC_IDX_INT_MASK = 6'h32;
	// ======================================================
	// control register fields
	localparam int TEC_CTRL_EXCESS_ZERO = 0;
	localparam int TEC_CTRL_ZERO_SUBST = 1;
	localparam int TEC_CTRL_FRAMING_ESF = 2;
	localparam int TEC_CTRL_FS_ERROR = 3;
	localparam int TEC_CTRL_OOS_MODE = 4;
	localparam int TEC_CTRL_W = 5;
	localparam logic [4:0] TEC_CTRL_RESET = 5'h00;
	// ======================================================
	// interrupt status and mask fields
	localparam int TEC_INT_UPDATE = 0;
	localparam int TEC_INT_LINE_SAT = 1;
	localparam int TEC_INT_PATH_SAT = 2;
	localparam int TEC_INT_MF_SAT = 3;
	localparam int TEC_INT_W = 4;
	localparam logic [3:0] TEC_INT_RESET = 4'h0;
	// ======================================================
	// zero run lengths
	localparam logic [4:0] TEC_ZERO_RUN_PLAIN = 5'h10;
	localparam logic [4:0] TEC_ZERO_RUN_SUBST = 5'h08;
	localparam logic [4:0] TEC_ZERO_COUNT_RESET = 5'h00;
endpackage : tec_pkg

//--- rtl/tec_sat_counter.sv
// saturating running counter with a latched copy taken on each boundary
`timescale 1ns/100ps
`default_nettype none
module tec_sat_counter
	import tec_pkg::*;
#(
	parameter int W = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic inc,
	input wire logic boundary,
	output logic [W-1:0] running,
	output logic [W-1:0] latched,
	output logic sat_hit
);
	logic at_max;

	assign at_max = &running;
	assign sat_hit = inc && at_max;

	// ======================================================
	// running accumulation
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			running <= '0;
		else if (boundary)
			running <= inc ? {{(W-1){1'b0}}, 1'b1} : '0;
		else if (inc && !at_max)
			running <= running + {{(W-1){1'b0}}, 1'b1};
	end

	// ======================================================
	// host copy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			latched <= '0;
		else if (boundary)
			latched <= running;
	end
endmodule : tec_sat_counter
`default_nettype wire

//--- rtl/tec_error_counters.sv
// receive error counters of a t1 framer with an apb register port
// ======================================================
`timescale 1ns/100ps
`default_nettype none
module tec_error_counters
	import tec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic one_second_flag,
	input wire logic bpv_strobe,
	input wire logic subst_code_strobe,
	input wire logic rx_bit_strobe,
	input wire logic rx_bit_zero,
	input wire logic crc6_error_strobe,
	input wire logic ft_error_strobe,
	input wire logic fs_error_strobe,
	input wire logic fps_error_strobe,
	input wire logic multiframe_strobe,
	input wire logic receiver_out_of_sync,
	input wire logic receive_sync_lost,
	output logic irq
);
	logic [TEC_CTRL_W-1:0] ctrl;
	logic [TEC_INT_W-1:0] int_status;
	logic [TEC_INT_W-1:0] int_mask;
	logic [TEC_INT_W-1:0] next_int_status;
	logic [TEC_INT_W-1:0] int_events;
	logic [TEC_INT_W-1:0] int_clear;
	logic [4:0] zero_count;
	logic [4:0] zero_limit;
	logic zero_event;
	logic bpv_counted;
	logic line_inc;
	logic path_inc;
	logic mf_inc;
	logic [TEC_LINE_W-1:0] line_running;
	logic [TEC_LINE_W-1:0] line_latched;
	logic [TEC_PATH_W-1:0] path_running;
	logic [TEC_PATH_W-1:0] path_latched;
	logic [TEC_MF_W-1:0] mf_running;
	logic [TEC_MF_W-1:0] mf_latched;
	logic line_sat;
	logic path_sat;
	logic mf_sat;
	logic [5:0] reg_index;
	logic bus_write;
	logic bus_setup;
	logic excess_zero_count_enable;
	logic receive_zero_substitution_enable;
	logic receive_framing_select;
	logic fs_error_count_enable;
	logic out_of_sync_mode_select;

	assign excess_zero_count_enable = ctrl[TEC_CTRL_EXCESS_ZERO];
	assign receive_zero_substitution_enable = ctrl[TEC_CTRL_ZERO_SUBST];
	assign receive_framing_select = ctrl[TEC_CTRL_FRAMING_ESF];
	assign fs_error_count_enable = ctrl[TEC_CTRL_FS_ERROR];
	assign out_of_sync_mode_select = ctrl[TEC_CTRL_OOS_MODE];

	// ======================================================
	// register decode
	function automatic logic reg_mapped(input logic [7:0] addr);
		logic [5:0] idx;
		idx = addr[7:2];
		reg_mapped = (addr[1:0] == 2'h0) &&
			((idx >= TEC_IDX_LINE_HIGH && idx <= TEC_IDX_MF_LOW) ||
			(idx >= TEC_IDX_CTRL && idx <= TEC_IDX_INT_MASK));
	endfunction : reg_mapped

	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		reg_read = 8'h00;
		if (reg_mapped(addr))
		begin
			case (addr[7:2])
				TEC_IDX_LINE_HIGH: reg_read = line_latched[15:8];
				TEC_IDX_LINE_LOW: reg_read = line_latched[7:0];
				TEC_IDX_PATH_MF_HIGH: reg_read = {mf_latched[11:8], path_latched[11:8]};
				TEC_IDX_PATH_LOW: reg_read = path_latched[7:0];
				TEC_IDX_MF_LOW: reg_read = mf_latched[7:0];
				TEC_IDX_CTRL: reg_read = {3'h0, ctrl};
				TEC_IDX_INT_STATUS: reg_read = {4'h0, int_status};
				TEC_IDX_INT_MASK: reg_read = {4'h0, int_mask};
				default: reg_read = 8'h00;
			endcase
		end
	endfunction : reg_read

	assign reg_index = paddr[7:2];
	assign bus_setup = psel && !penable;
	assign bus_write = psel && penable && pwrite && reg_mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_mapped(paddr);

	// ======================================================
	// read data, sampled in the setup cycle; reads have no side effect
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (bus_setup)
			prdata <= {24'h000000, reg_read(paddr)};
	end

	// ======================================================
	// control register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= TEC_CTRL_RESET;
		else if (bus_write && reg_index == TEC_IDX_CTRL)
			ctrl <= pwdata[TEC_CTRL_W-1:0];
	end

	// ======================================================
	// interrupts: sticky status, write one to clear, set wins
	assign int_events = {mf_sat, path_sat, line_sat, one_second_flag};
	assign int_clear = (bus_write && reg_index == TEC_IDX_INT_STATUS) ?
		pwdata[TEC_INT_W-1:0] : TEC_INT_RESET;

	always_comb
	begin
		next_int_status = (int_status & ~int_clear) | int_events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_status <= TEC_INT_RESET;
		else
			int_status <= next_int_status;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_mask <= TEC_INT_RESET;
		else if (bus_write && reg_index == TEC_IDX_INT_MASK)
			int_mask <= pwdata[TEC_INT_W-1:0];
	end

	assign irq = |(int_status & int_mask);

	// ======================================================
	// zero run detection on the received bit stream
	assign zero_limit = receive_zero_substitution_enable ? TEC_ZERO_RUN_SUBST :
		TEC_ZERO_RUN_PLAIN;
	assign zero_event = excess_zero_count_enable && rx_bit_strobe && rx_bit_zero &&
		(zero_count == zero_limit - 5'h01);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			zero_count <= TEC_ZERO_COUNT_RESET;
		else if (rx_bit_strobe)
		begin
			if (!rx_bit_zero || zero_event)
				zero_count <= TEC_ZERO_COUNT_RESET;
			else if (zero_count < zero_limit - 5'h01)
				zero_count <= zero_count + 5'h01;
		end
	end

	// ======================================================
	// increment selection
	assign bpv_counted = bpv_strobe &&
		!(receive_zero_substitution_enable && subst_code_strobe);
	assign line_inc = bpv_counted || zero_event;

	always_comb
	begin
		if (receive_framing_select)
			path_inc = crc6_error_strobe;
		else
			path_inc = ft_error_strobe || (fs_error_count_enable && fs_error_strobe);
		if (receive_sync_lost)
			path_inc = 1'b0;
	end

	always_comb
	begin
		if (out_of_sync_mode_select)
			mf_inc = multiframe_strobe && receiver_out_of_sync;
		else if (receive_sync_lost)
			mf_inc = 1'b0;
		else if (receive_framing_select)
			mf_inc = fps_error_strobe;
		else
			mf_inc = ft_error_strobe;
	end

	// ======================================================
	// counters
	tec_sat_counter #(.W(TEC_LINE_W)) u_line_violation_counter (
		.pclk(pclk),
		.presetn(presetn),
		.inc(line_inc),
		.boundary(one_second_flag),
		.running(line_running),
		.latched(line_latched),
		.sat_hit(line_sat)
	);

	tec_sat_counter #(.W(TEC_PATH_W)) u_path_error_counter (
		.pclk(pclk),
		.presetn(presetn),
		.inc(path_inc),
		.boundary(one_second_flag),
		.running(path_running),
		.latched(path_latched),
		.sat_hit(path_sat)
	);

	tec_sat_counter #(.W(TEC_MF_W)) u_multiframe_counter (
		.pclk(pclk),
		.presetn(presetn),
		.inc(mf_inc),
		.boundary(one_second_flag),
		.running(mf_running),
		.latched(mf_latched),
		.sat_hit(mf_sat)
	);

	// ======================================================
	// checks
	chk_latch_on_second: assert property (@(posedge pclk) disable iff (!presetn)
		one_second_flag |=> (line_latched == $past(line_running)) &&
		(path_latched == $past(path_running)) && (mf_latched == $past(mf_running)))
		else $error("counter copies not refreshed on the second");

	chk_copy_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!one_second_flag |=> $stable(line_latched) && $stable(path_latched) &&
		$stable(mf_latched))
		else $error("counter copy changed between seconds");

	chk_line_saturate: assert property (@(posedge pclk) disable iff (!presetn)
		(line_running == 16'hFFFF) && !one_second_flag |=> line_running == 16'hFFFF)
		else $error("line counter left full scale");

	chk_line_count_los: assert property (@(posedge pclk) disable iff (!presetn)
		bpv_strobe && !subst_code_strobe && receive_sync_lost && !one_second_flag &&
		(line_running != 16'hFFFF) |=> line_running == $past(line_running) + 16'h0001)
		else $error("line counter missed a violation");

	chk_subst_skip: assert property (@(posedge pclk) disable iff (!presetn)
		receive_zero_substitution_enable && subst_code_strobe && !zero_event &&
		!one_second_flag |=> $stable(line_running))
		else $error("substitution code counted as violation");

	chk_zero_run: assert property (@(posedge pclk) disable iff (!presetn)
		excess_zero_count_enable && rx_bit_strobe && rx_bit_zero && !bpv_strobe &&
		!one_second_flag && (line_running != 16'hFFFF) &&
		(zero_count == (receive_zero_substitution_enable ? 5'h07 : 5'h0F))
		|=> line_running == $past(line_running) + 16'h0001)
		else $error("zero run not counted");

	chk_path_crc: assert property (@(posedge pclk) disable iff (!presetn)
		receive_framing_select && crc6_error_strobe && !receive_sync_lost &&
		!one_second_flag && (path_running != 12'hFFF)
		|=> path_running == $past(path_running) + 12'h001)
		else $error("crc6 error not counted");

	chk_path_los: assert property (@(posedge pclk) disable iff (!presetn)
		receive_sync_lost && !one_second_flag |=> $stable(path_running))
		else $error("path counter moved during loss of sync");

	chk_mf_oos: assert property (@(posedge pclk) disable iff (!presetn)
		out_of_sync_mode_select && multiframe_strobe && receiver_out_of_sync &&
		!one_second_flag && (mf_running != 12'hFFF)
		|=> mf_running == $past(mf_running) + 12'h001)
		else $error("out of sync multiframe not counted");

	chk_mf_fbit_los: assert property (@(posedge pclk) disable iff (!presetn)
		!out_of_sync_mode_select && receive_sync_lost && !one_second_flag
		|=> $stable(mf_running))
		else $error("framing error count moved during loss of sync");

	chk_path_saturate: assert property (@(posedge pclk) disable iff (!presetn)
		(path_running == 12'hFFF) && !one_second_flag |=> path_running == 12'hFFF)
		else $error("path counter left full scale");

	chk_mf_saturate: assert property (@(posedge pclk) disable iff (!presetn)
		(mf_running == 12'hFFF) && !one_second_flag |=> mf_running == 12'hFFF)
		else $error("multiframe counter left full scale");

	chk_running_clear: assert property (@(posedge pclk) disable iff (!presetn)
		one_second_flag |=> (line_running == {15'h0000, $past(line_inc)}) &&
		(path_running == {11'h000, $past(path_inc)}) &&
		(mf_running == {11'h000, $past(mf_inc)}))
		else $error("running count not restarted on the second");

	chk_path_ft: assert property (@(posedge pclk) disable iff (!presetn)
		!receive_framing_select && !receive_sync_lost && ft_error_strobe &&
		!one_second_flag && (path_running != 12'hFFF)
		|=> path_running == $past(path_running) + 12'h001)
		else $error("ft error not counted in path counter");

	chk_path_fs_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!receive_framing_select && !fs_error_count_enable && fs_error_strobe &&
		!ft_error_strobe && !one_second_flag |=> $stable(path_running))
		else $error("fs error counted while disabled");

	chk_mf_fbit: assert property (@(posedge pclk) disable iff (!presetn)
		!out_of_sync_mode_select && !receive_sync_lost && !one_second_flag &&
		(receive_framing_select ? fps_error_strobe : ft_error_strobe) &&
		(mf_running != 12'hFFF) |=> mf_running == $past(mf_running) + 12'h001)
		else $error("framing pattern error not counted");

	chk_read_line_high: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && (paddr == {TEC_IDX_LINE_HIGH, 2'b00})
		|=> prdata == {24'h000000, $past(line_latched[15:8])})
		else $error("line count high byte read wrong");

	chk_read_shared: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && (paddr == {TEC_IDX_PATH_MF_HIGH, 2'b00})
		|=> prdata == {24'h000000, $past(mf_latched[11:8]), $past(path_latched[11:8])})
		else $error("shared high nibble read wrong");
endmodule : tec_error_counters
`default_nettype wire

//--- test/tec_host_model.sv
// host side model: apb master that reads and writes the counter block registers
`timescale 1ns/100ps
`default_nettype none
module tec_host_model
	import tec_pkg::*;
(
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// ======================================================
	// one transfer; copies are read soon after each boundary, well inside their second
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdat, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data does not keep its last value
		pwdata <= ~wd;
	endtask : xfer
endmodule : tec_host_model
`default_nettype wire

//--- test/tec_error_counters_tb.sv
// self-checking bench for the receive error counter block
`timescale 1ns/100ps
`default_nettype none
module tec_error_counters_tb
	import tec_pkg::*;
;
	localparam logic [6:0] E_BPV = 7'h40;
	localparam logic [6:0] E_SUB = 7'h20;
	localparam logic [6:0] E_CRC = 7'h10;
	localparam logic [6:0] E_FT = 7'h08;
	localparam logic [6:0] E_FS = 7'h04;
	localparam logic [6:0] E_FPS = 7'h02;
	localparam logic [6:0] E_MF = 7'h01;
	logic pclk;
	logic presetn = 1'b0, osf = 1'b0, bit_stb = 1'b0, bit_zero = 1'b0, oos = 1'b0, lost = 1'b0;
	logic [6:0] ev_v = 7'h00;
	logic psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [4:0] modes [4] = '{5'h00, 5'h08, 5'h04, 5'h0C};
	logic [11:0] pexp [4] = '{12'h003, 12'h006, 12'h003, 12'h003};

	tec_error_counters dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .one_second_flag(osf), .bpv_strobe(ev_v[6]),
		.subst_code_strobe(ev_v[5]), .rx_bit_strobe(bit_stb), .rx_bit_zero(bit_zero),
		.crc6_error_strobe(ev_v[4]), .ft_error_strobe(ev_v[3]), .fs_error_strobe(ev_v[2]),
		.fps_error_strobe(ev_v[1]), .multiframe_strobe(ev_v[0]),
		.receiver_out_of_sync(oos), .receive_sync_lost(lost), .irq(irq));
	tec_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial
	begin
		pclk = 1'b0;
		forever
			#10 pclk = ~pclk;
	end

	// ======================================================
	// helpers
	task conclude();
		if (errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			errors++;
			conclude();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task rd_chk(input logic [5:0] idx, input logic [31:0] exp, input logic exp_err);
		host.xfer(1'b0, {idx, 2'b00}, 32'h00000000, rd, err);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, exp_err});
	endtask : rd_chk
	task wr(input logic [5:0] idx, input logic [31:0] d);
		host.xfer(1'b1, {idx, 2'b00}, d, rd, err);
		chk({31'h0, err}, 32'h00000000);
	endtask : wr
	task ev(input logic [6:0] v, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			ev_v <= v;
		end
		@(posedge pclk);
		ev_v <= 7'h00;
	endtask : ev
	task bits(input int n, input logic z);
		repeat (n)
		begin
			@(posedge pclk);
			bit_stb <= 1'b1;
			bit_zero <= z;
		end
		@(posedge pclk);
		bit_stb <= 1'b0;
	endtask : bits
	task sec();
		@(posedge pclk);
		osf <= 1'b1;
		@(posedge pclk);
		osf <= 1'b0;
		@(posedge pclk);
	endtask : sec
	task cnt_chk(input logic [15:0] l, input logic [11:0] p, input logic [11:0] m);
		rd_chk(TEC_IDX_LINE_HIGH, {24'h0, l[15:8]}, 1'b0);
		rd_chk(TEC_IDX_LINE_LOW, {24'h0, l[7:0]}, 1'b0);
		rd_chk(TEC_IDX_PATH_MF_HIGH, {24'h0, m[11:8], p[11:8]}, 1'b0);
		rd_chk(TEC_IDX_PATH_LOW, {24'h0, p[7:0]}, 1'b0);
		rd_chk(TEC_IDX_MF_LOW, {24'h0, m[7:0]}, 1'b0);
	endtask : cnt_chk

	// ======================================================
	// scenarios
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(TEC_IDX_CTRL, 32'h00000000, 1'b0);
		rd_chk(TEC_IDX_INT_MASK, 32'h00000000, 1'b0);
		rd_chk(6'h3F, 32'h00000000, 1'b1);
		host.xfer(1'b0, 8'h8D, 32'h00000000, rd, err);
		chk({31'h0, err}, 32'h00000001);
		wr(TEC_IDX_LINE_LOW, 32'h000000FF);
		cnt_chk(16'h0000, 12'h000, 12'h000);
		lost <= 1'b1;
		ev(E_BPV, 5);
		sec();
		cnt_chk(16'h0005, 12'h000, 12'h000);
		@(posedge pclk);
		osf <= 1'b1;
		ev_v <= E_BPV;
		@(posedge pclk);
		osf <= 1'b0;
		ev_v <= 7'h00;
		ev(E_BPV, 2);
		cnt_chk(16'h0000, 12'h000, 12'h000);
		sec();
		cnt_chk(16'h0003, 12'h000, 12'h000);
		chk({31'h0, irq}, 32'h00000000);
		wr(TEC_IDX_INT_MASK, 32'h00000001);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h00000001);
		wr(TEC_IDX_INT_STATUS, 32'h00000001);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h00000000);
		rd_chk(TEC_IDX_INT_STATUS, 32'h00000000, 1'b0);
		wr(TEC_IDX_CTRL, 32'h00000002);
		ev(E_BPV | E_SUB, 3);
		ev(E_BPV, 2);
		sec();
		cnt_chk(16'h0002, 12'h000, 12'h000);
		wr(TEC_IDX_CTRL, 32'h00000000);
		ev(E_BPV | E_SUB, 3);
		sec();
		cnt_chk(16'h0003, 12'h000, 12'h000);
		wr(TEC_IDX_CTRL, 32'h00000001);
		bits(32, 1'b1);
		bits(15, 1'b1);
		bits(1, 1'b0);
		bits(15, 1'b1);
		sec();
		cnt_chk(16'h0002, 12'h000, 12'h000);
		wr(TEC_IDX_CTRL, 32'h00000003);
		bits(1, 1'b0);
		bits(16, 1'b1);
		sec();
		cnt_chk(16'h0002, 12'h000, 12'h000);
		lost <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			wr(TEC_IDX_CTRL, {27'h0, modes[i]});
			repeat (3)
			begin
				ev(E_FT, 1);
				ev(E_FS, 1);
				ev(E_CRC, 1);
				ev(E_FPS, 1);
			end
			sec();
			cnt_chk(16'h0000, pexp[i], 12'h003);
		end
		wr(TEC_IDX_CTRL, 32'h00000000);
		lost <= 1'b1;
		ev(E_FT, 2);
		ev(E_BPV, 1);
		sec();
		cnt_chk(16'h0001, 12'h000, 12'h000);
		wr(TEC_IDX_CTRL, 32'h00000010);
		oos <= 1'b1;
		ev(E_MF, 4);
		ev(E_FT, 2);
		oos <= 1'b0;
		ev(E_MF, 2);
		sec();
		cnt_chk(16'h0000, 12'h000, 12'h004);
		lost <= 1'b0;
		wr(TEC_IDX_INT_STATUS, 32'h0000000F);
		wr(TEC_IDX_INT_MASK, 32'h00000004);
		oos <= 1'b1;
		ev(E_BPV | E_FT | E_MF, 65540);
		sec();
		cnt_chk(16'hFFFF, 12'hFFF, 12'hFFF);
		rd_chk(TEC_IDX_INT_STATUS, 32'h0000000F, 1'b0);
		chk({31'h0, irq}, 32'h00000001);
		ev(E_BPV, 1);
		sec();
		cnt_chk(16'h0001, 12'h000, 12'h000);
		conclude();
	end
endmodule : tec_error_counters_tb
`default_nettype wire
